// >>> rtfi_irq_unit.sv
/*
  Interrupt unit of the serial data controller: receive label interrupts, transmit
  threshold interrupts, fault interrupts, pending registers with read-clear and the
  active-low interrupt pin with acknowledge.
  Assumes the host port logic issues single-cycle byte read and write strobes and
  samples rdata_o one cycle after the read strobe; event inputs are on mclk_i;
  the acknowledge pin comes from outside and is synchronised here.
*/
`timescale 1ns/1ps
//
// What this block does
// - receive interrupt lookup gates each channel and label
// - flagged message sets pending bit, captures label
// - label is message bits one through eight
// - channel n maps to pending bit n
// - enabled pending drives int low until acknowledge
// - acknowledge held low gives one microsecond pulse
// - reading receive pending returns and clears it
// - enabled transmit threshold flag rise asserts interrupt
// - fault bits unmaskable, mask bits read one
// - copy mismatch sets pending bit six
// - autoinit verify mismatch sets pending bit five
// - autoinit checksum fail sets pending bit four
// - ram test failure sets pending bit three
// - receive enable pair gates pending bits individually
// - general pending bits assert the interrupt; bits two to zero only when enabled
// - reading general pending returns and clears it
// - any new message sets bit two, writable
// - bit one rx fifo or, bit zero tx
// - eeprom program abort sets pending bit seven
// - sixteen read-only label capture registers, consecutive
// - receive pending also at alternate addresses
// - fifo summary bits need their enables set
module rtfi_irq_unit (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // host register access
  input wire rtfi_pkg::rtfi_reg_req_t reg_req_i,
  output logic [7:0] rdata_o,
  // receive interrupt lookup table load
  input wire rtfi_pkg::rtfi_lut_wr_t lut_wr_i,
  // event sources
  input wire rtfi_pkg::rtfi_rx_msg_t rx_msg_i,
  input wire logic [15:0] rx_fifo_flag_i,
  input wire logic [7:0] tx_fifo_thresh_i,
  input wire rtfi_pkg::rtfi_fault_t fault_i,
  // host interrupt pins
  input wire logic ack_n_i,
  output logic int_n_o
);
  import rtfi_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_LEVEL, ST_PULSE} rtfi_pin_state_t;

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic lookup_r [RX_CHANNELS*LABEL_VALUES];
  logic [7:0] label_cap_r [RX_CHANNELS];
  logic [15:0] rx_pend_r;
  logic [15:0] rx_pend_set;
  logic [15:0] rx_irq_en_r;
  logic [7:0] gen_pend_r;
  logic [7:0] gen_pend_set;
  logic [2:0] gen_en_r;
  logic [7:0] tx_flag_en_r;
  logic [7:0] tx_thresh_d_r;
  logic [7:0] rx_label;
  logic msg_flagged;
  logic tx_event;
  logic irq_cause;
  logic irq_cause_d_r;
  logic irq_new;
  logic ack_meta_r;
  logic ack_sync_r;
  logic [PULSE_CNT_W-1:0] pulse_cnt_r;
  rtfi_pin_state_t pin_state_r;
  logic rd_gen;
  logic rd_rx_lo;
  logic rd_rx_hi;
  logic wr_gen;
  logic [7:0] rdata_nxt;

  // ****************************************************************
  // event decode
  // ****************************************************************
  // label byte is word bits 1..8, i.e. the low byte
  assign rx_label = rx_msg_i.word[7:0];
  assign msg_flagged = rx_msg_i.valid & lookup_r[{rx_msg_i.channel, rx_label}];
  assign tx_event = |(tx_fifo_thresh_i & ~tx_thresh_d_r & tx_flag_en_r);

  // receive pending set, one bit per channel
  always_comb
  begin
    rx_pend_set = 16'h0000;
    if (msg_flagged)
    begin
      rx_pend_set[rx_msg_i.channel] = 1'b1;
    end
  end

  always_comb
  begin
    gen_pend_set = 8'h00;
    gen_pend_set[BIT_EEPROM_PROGRAM_ABORT] = fault_i.program_abort;
    gen_pend_set[BIT_EEPROM_COPY_MISMATCH] = fault_i.copy_mismatch;
    gen_pend_set[BIT_AUTOINIT_VERIFY_MISMATCH] = fault_i.verify_mismatch;
    gen_pend_set[BIT_AUTOINIT_CHECKSUM_FAIL] = fault_i.checksum_fail;
    gen_pend_set[BIT_RAM_TEST_FAIL] = fault_i.ram_fail;
    gen_pend_set[BIT_ANY_NEW_RX_MESSAGE] = rx_msg_i.valid;
    gen_pend_set[BIT_RX_FIFO_FLAG_ANY] = |rx_fifo_flag_i;
    gen_pend_set[BIT_TX_FIFO_FLAG_ANY] = |tx_fifo_thresh_i;
  end

  // ****************************************************************
  // register access decode
  // ****************************************************************
  assign rd_gen = reg_req_i.rd & (reg_req_i.addr == GEN_PEND_OFS || reg_req_i.addr == GEN_PEND_ALT_OFS);
  assign rd_rx_lo = reg_req_i.rd & (reg_req_i.addr == RX_PEND_LO_OFS || reg_req_i.addr == RX_PEND_LO_ALT_OFS);
  assign rd_rx_hi = reg_req_i.rd & (reg_req_i.addr == RX_PEND_HI_OFS || reg_req_i.addr == RX_PEND_HI_ALT_OFS);
  assign wr_gen = reg_req_i.wr & (reg_req_i.addr == GEN_PEND_OFS || reg_req_i.addr == GEN_PEND_ALT_OFS);

  // ****************************************************************
  // receive interrupt lookup table
  // ****************************************************************
  // one bit per channel and label; not reset, loaded by configuration
  always_ff @(posedge mclk_i)
  begin
    if (lut_wr_i.we)
    begin
      lookup_r[{lut_wr_i.channel, lut_wr_i.label}] <= lut_wr_i.set;
    end
  end

  // ****************************************************************
  // label capture registers
  // ****************************************************************
  genvar gc;
  generate
    for (gc = 0; gc < RX_CHANNELS; gc++)
    begin : g_cap
      always_ff @(posedge mclk_i)
      begin
        if (!rst_n_i)
        begin
          label_cap_r[gc] <= LABEL_CAP_RST;
        end
        else if (rx_pend_set[gc])
        begin
          label_cap_r[gc] <= rx_label;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // pending registers
  // ****************************************************************
  // new sets win over a read-clear in the same cycle
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      rx_pend_r <= RX_PEND_RST;
    end
    else
    begin
      rx_pend_r[7:0] <= (rd_rx_lo ? 8'h00 : rx_pend_r[7:0]) | rx_pend_set[7:0];
      rx_pend_r[15:8] <= (rd_rx_hi ? 8'h00 : rx_pend_r[15:8]) | rx_pend_set[15:8];
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      gen_pend_r <= GEN_PEND_RST;
    end
    else if (wr_gen)
    begin
      // only the new-message bit is writable
      gen_pend_r[BIT_ANY_NEW_RX_MESSAGE] <= reg_req_i.wdata[BIT_ANY_NEW_RX_MESSAGE]
        | gen_pend_set[BIT_ANY_NEW_RX_MESSAGE];
      gen_pend_r[7:3] <= gen_pend_r[7:3] | gen_pend_set[7:3];
      gen_pend_r[1:0] <= gen_pend_r[1:0] | gen_pend_set[1:0];
    end
    else
    begin
      gen_pend_r <= (rd_gen ? 8'h00 : gen_pend_r) | gen_pend_set;
    end
  end

  // ****************************************************************
  // enable registers
  // ****************************************************************
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      rx_irq_en_r <= RX_IRQ_EN_RST;
      gen_en_r <= GEN_ENABLE_RST;
      tx_flag_en_r <= TX_FLAG_IRQ_EN_RST;
    end
    else if (reg_req_i.wr)
    begin
      case (reg_req_i.addr)
        RX_IRQ_EN_LO_OFS: rx_irq_en_r[7:0] <= reg_req_i.wdata;
        RX_IRQ_EN_HI_OFS: rx_irq_en_r[15:8] <= reg_req_i.wdata;
        GEN_ENABLE_OFS: gen_en_r <= reg_req_i.wdata[2:0];
        TX_FLAG_IRQ_EN_OFS: tx_flag_en_r <= reg_req_i.wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      tx_thresh_d_r <= 8'h00;
    end
    else
    begin
      tx_thresh_d_r <= tx_fifo_thresh_i;
    end
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  always_comb
  begin
    rdata_nxt = 8'h00;
    if (reg_req_i.addr >= LABEL_CAP_BASE_OFS && reg_req_i.addr <= LABEL_CAP_LAST_OFS)
    begin
      rdata_nxt = label_cap_r[reg_req_i.addr[3:0]];
    end
    else
    begin
      case (reg_req_i.addr)
        GEN_PEND_OFS, GEN_PEND_ALT_OFS: rdata_nxt = gen_pend_r;
        RX_PEND_LO_OFS, RX_PEND_LO_ALT_OFS: rdata_nxt = rx_pend_r[7:0];
        RX_PEND_HI_OFS, RX_PEND_HI_ALT_OFS: rdata_nxt = rx_pend_r[15:8];
        GEN_ENABLE_OFS: rdata_nxt = {FAULT_MASK_FIXED, gen_en_r};
        RX_IRQ_EN_LO_OFS: rdata_nxt = rx_irq_en_r[7:0];
        RX_IRQ_EN_HI_OFS: rdata_nxt = rx_irq_en_r[15:8];
        TX_FLAG_IRQ_EN_OFS: rdata_nxt = tx_flag_en_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      rdata_o <= 8'h00;
    end
    else if (reg_req_i.rd)
    begin
      rdata_o <= rdata_nxt;
    end
  end

  // ****************************************************************
  // interrupt cause
  // ****************************************************************
  assign irq_cause = |(rx_pend_r & rx_irq_en_r)
    | (|gen_pend_r[7:3])
    | (gen_pend_r[BIT_ANY_NEW_RX_MESSAGE] & gen_en_r[BIT_ANY_NEW_RX_MESSAGE])
    | (gen_pend_r[BIT_RX_FIFO_FLAG_ANY] & gen_en_r[BIT_RX_FIFO_FLAG_ANY])
    | (gen_pend_r[BIT_TX_FIFO_FLAG_ANY] & gen_en_r[BIT_TX_FIFO_FLAG_ANY]);

  // new event: cause rises, an enabled receive pending bit sets, or an enabled transmit threshold rises
  assign irq_new = (irq_cause & ~irq_cause_d_r) | tx_event | (|(rx_pend_set & rx_irq_en_r));

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      irq_cause_d_r <= 1'b0;
    end
    else
    begin
      irq_cause_d_r <= irq_cause;
    end
  end

  // ****************************************************************
  // acknowledge synchroniser
  // ****************************************************************
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      ack_meta_r <= 1'b1;
      ack_sync_r <= 1'b1;
    end
    else
    begin
      ack_meta_r <= ack_n_i;
      ack_sync_r <= ack_meta_r;
    end
  end

  // ****************************************************************
  // interrupt pin
  // ****************************************************************
  // acknowledge level picks level or pulse signalling
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      pin_state_r <= ST_IDLE;
      pulse_cnt_r <= '0;
      int_n_o <= 1'b1;
    end
    else
    begin
      case (pin_state_r)
        ST_IDLE:
        begin
          if (irq_new && ack_sync_r)
          begin
            pin_state_r <= ST_LEVEL;
            int_n_o <= 1'b0;
          end
          else if (irq_new)
          begin
            pin_state_r <= ST_PULSE;
            pulse_cnt_r <= PULSE_CNT_W'(PULSE_CYCLES - 1);
            int_n_o <= 1'b0;
          end
        end
        ST_LEVEL:
        begin
          if (!ack_sync_r)
          begin
            pin_state_r <= ST_IDLE;
            int_n_o <= 1'b1;
          end
        end
        ST_PULSE:
        begin
          if (pulse_cnt_r == '0)
          begin
            pin_state_r <= ST_IDLE;
            int_n_o <= 1'b1;
          end
          else
          begin
            pulse_cnt_r <= pulse_cnt_r - 1'b1;
          end
        end
        default:
        begin
          pin_state_r <= ST_IDLE;
          int_n_o <= 1'b1;
        end
      endcase
    end
  end

endmodule // rtfi_irq_unit

// >>> rtfi_pkg.sv
/*
  Package of the rx/tx/fault interrupt unit: register offsets, field positions,
  reset values, timing counts and the carrier structs.
  Assumes a 100 MHz master clock and byte-wide register access from the host port logic.
*/
package rtfi_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [15:0] GEN_PEND_OFS = 16'h8004;
  localparam logic [15:0] GEN_PEND_ALT_OFS = 16'h800A;
  localparam logic [15:0] RX_PEND_LO_OFS = 16'h8006;
  localparam logic [15:0] RX_PEND_HI_OFS = 16'h8008;
  localparam logic [15:0] RX_PEND_LO_ALT_OFS = 16'h800B;
  localparam logic [15:0] RX_PEND_HI_ALT_OFS = 16'h800C;
  localparam logic [15:0] LABEL_CAP_BASE_OFS = 16'h8010;
  localparam logic [15:0] LABEL_CAP_LAST_OFS = 16'h801F;
  localparam logic [15:0] GEN_ENABLE_OFS = 16'h804A;
  localparam logic [15:0] RX_IRQ_EN_LO_OFS = 16'h804B;
  localparam logic [15:0] RX_IRQ_EN_HI_OFS = 16'h804C;
  localparam logic [15:0] TX_FLAG_IRQ_EN_OFS = 16'h804D;

  // ****************************************************************
  // general pending flag positions
  // ****************************************************************
  localparam int BIT_EEPROM_PROGRAM_ABORT = 7;
  localparam int BIT_EEPROM_COPY_MISMATCH = 6;
  localparam int BIT_AUTOINIT_VERIFY_MISMATCH = 5;
  localparam int BIT_AUTOINIT_CHECKSUM_FAIL = 4;
  localparam int BIT_RAM_TEST_FAIL = 3;
  localparam int BIT_ANY_NEW_RX_MESSAGE = 2;
  localparam int BIT_RX_FIFO_FLAG_ANY = 1;
  localparam int BIT_TX_FIFO_FLAG_ANY = 0;

  // ****************************************************************
  // reset values and fixed masks
  // ****************************************************************
  localparam logic [7:0] GEN_PEND_RST = 8'h00;
  localparam logic [15:0] RX_PEND_RST = 16'h0000;
  localparam logic [15:0] RX_IRQ_EN_RST = 16'h0000;
  localparam logic [2:0] GEN_ENABLE_RST = 3'h0;
  localparam logic [7:0] TX_FLAG_IRQ_EN_RST = 8'h00;
  localparam logic [7:0] LABEL_CAP_RST = 8'h00;
  localparam logic [4:0] FAULT_MASK_FIXED = 5'h1F;

  // ****************************************************************
  // sizes and timing
  // ****************************************************************
  localparam int RX_CHANNELS = 16;
  localparam int TX_CHANNELS = 8;
  localparam int LABEL_VALUES = 256;
  localparam int CLK_PERIOD_PS = 10000;
  localparam int PULSE_TIME_NS = 1000;
  localparam int PULSE_CYCLES = (PULSE_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int PULSE_CNT_W = 8;

  // ****************************************************************
  // carrier structs
  // ****************************************************************
  typedef struct packed {
    logic valid;
    logic [3:0] channel;
    logic [31:0] word;
  } rtfi_rx_msg_t;

  typedef struct packed {
    logic program_abort;
    logic copy_mismatch;
    logic verify_mismatch;
    logic checksum_fail;
    logic ram_fail;
  } rtfi_fault_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } rtfi_reg_req_t;

  typedef struct packed {
    logic we;
    logic [3:0] channel;
    logic [7:0] label;
    logic set;
  } rtfi_lut_wr_t;

endpackage

// >>> rtfi_irq_unit_chk.sv
/* port checker of the interrupt unit.
   assumes binding onto rtfi_irq_unit, one clock domain. */
`timescale 1ns/1ps
module rtfi_irq_unit_chk (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // host side
  input wire rtfi_pkg::rtfi_reg_req_t reg_req_i,
  input wire logic [7:0] rdata_o,
  // events and pins
  input wire rtfi_pkg::rtfi_rx_msg_t rx_msg_i,
  input wire logic [15:0] rx_fifo_flag_i,
  input wire logic [7:0] tx_fifo_thresh_i,
  input wire rtfi_pkg::rtfi_fault_t fault_i,
  input wire logic ack_n_i,
  input wire logic int_n_o
);
  import rtfi_pkg::*;
  // ****
  // assertions
  // ****
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  logic rd;
  logic [15:0] a;
  logic quiet;
  assign rd = reg_req_i.rd;
  assign a = reg_req_i.addr;
  // no event source active
  assign quiet = !rx_msg_i.valid && !reg_req_i.wr && fault_i == '0 && rx_fifo_flag_i == '0 && tx_fifo_thresh_i == '0;
  chk_reset_idle: assert property (disable iff (1'b0) !rst_n_i |=> int_n_o && rdata_o == 8'h00)
    else $error("outputs not idle after reset");
  chk_unmapped_zero: assert property (rd && a[15:2] == 14'h2000 |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  chk_fault_mask: assert property (rd && a == GEN_ENABLE_OFS |=> rdata_o[7:3] == 5'h1F)
    else $error("fault mask bits not one");
  chk_rxpend_clear: assert property ($past(quiet) && quiet && rd && a == RX_PEND_LO_OFS ##1
    rd && a == RX_PEND_LO_OFS |=> rdata_o == 8'h00)
    else $error("rx pending not cleared by read");
  chk_genpend_clear: assert property ($past(quiet) && quiet && rd && a == GEN_PEND_OFS ##1
    rd && a == GEN_PEND_OFS |=> rdata_o == 8'h00)
    else $error("general pending not cleared by read");
  chk_rdata_hold: assert property (!rd |=> $stable(rdata_o))
    else $error("read data moved without a read");
  chk_en_readback: assert property (reg_req_i.wr && a == RX_IRQ_EN_LO_OFS ##1 rd && a == RX_IRQ_EN_LO_OFS
    |=> rdata_o == $past(reg_req_i.wdata, 2))
    else $error("enable readback differs");
  chk_level_hold: assert property (!int_n_o && ack_n_i && $past(ack_n_i) && $past(ack_n_i, 2)
    && $past(ack_n_i, 3) |=> !int_n_o)
    else $error("int released without ack");
  chk_ack_release: assert property ($fell(ack_n_i) && !int_n_o |-> ##[1:4] int_n_o)
    else $error("int not released by ack");
  chk_pulse_len: assert property ($fell(int_n_o) && !ack_n_i && !$past(ack_n_i, 4)
    |-> ##99 !int_n_o ##1 int_n_o)
    else $error("pulse width wrong");
  cov_pulse: cover property ($fell(int_n_o) && !ack_n_i);
  cov_level: cover property ($fell(ack_n_i) && !int_n_o);
  cov_alt_read: cover property (rd && a == RX_PEND_LO_ALT_OFS);
endmodule // rtfi_irq_unit_chk

bind rtfi_irq_unit rtfi_irq_unit_chk chk_i (.mclk_i, .rst_n_i, .reg_req_i, .rdata_o, .rx_msg_i,
  .rx_fifo_flag_i, .tx_fifo_thresh_i, .fault_i, .ack_n_i, .int_n_o);

// >>> rtfi_host_model.sv
/* host cpu model on the interrupt and acknowledge pins.
   assumes mclk_i of the unit; drives just after the rising edge. */
`timescale 1ns/1ps
module rtfi_host_model (
  // pins
  input wire logic mclk_i,
  input wire logic int_n_i,
  input wire logic pulse_mode_i,
  output logic ack_n_o
);
  int wait_cnt = 0;
  initial ack_n_o = 1'b1;
  // static low selects pulse style, else negative ack pulse
  always @(posedge mclk_i)
  begin
    #1;
    if (pulse_mode_i) ack_n_o = 1'b0;
    else if (int_n_i === 1'b0)
    begin
      if (wait_cnt < 5) wait_cnt++;
      else ack_n_o = 1'b0;
    end
    else
    begin
      wait_cnt = 0;
      ack_n_o = 1'b1;
    end
  end
endmodule // rtfi_host_model

// >>> rtfi_irq_unit_tb.sv
/* self-checking bench of the interrupt unit.
   assumes package, unit, checker and host model compiled first. */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("FAIL %s exp %h got %h", nm, ex, got); end end
module rtfi_irq_unit_tb;
  import rtfi_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  rtfi_reg_req_t req = '0;
  rtfi_lut_wr_t lut = '0;
  rtfi_rx_msg_t msg = '0;
  logic [15:0] rx_flag = '0;
  logic [7:0] tx_flag = '0;
  rtfi_fault_t fault = '0;
  logic pulse_mode = 1'b0;
  logic ack_n;
  logic int_n;
  logic [7:0] rdata;
  logic [7:0] v;
  int n_mismatch = 0;
  int checks = 0;
  int cycles = 0;
  always #5 mclk_i = ~mclk_i;
  rtfi_irq_unit dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_req_i(req), .rdata_o(rdata),
    .lut_wr_i(lut), .rx_msg_i(msg), .rx_fifo_flag_i(rx_flag), .tx_fifo_thresh_i(tx_flag),
    .fault_i(fault), .ack_n_i(ack_n), .int_n_o(int_n));
  rtfi_host_model host (.mclk_i(mclk_i), .int_n_i(int_n), .pulse_mode_i(pulse_mode), .ack_n_o(ack_n));
  // ****
  // bus and event tasks
  // ****
  task automatic tick(input int n = 1);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    tick();
    req.wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input int n = 1);
    req.addr = a;
    req.rd = 1'b1;
    tick(n);
    req.rd = 1'b0;
    tick();
    v = rdata;
  endtask
  task automatic lut_set(input logic [3:0] c, input logic [7:0] l, input logic s);
    lut = '{we: 1'b1, channel: c, label: l, set: s};
    tick();
    lut.we = 1'b0;
    tick();
  endtask
  task automatic send(input logic [3:0] c, input logic [31:0] w);
    msg = '{valid: 1'b1, channel: c, word: w};
    tick();
    msg.valid = 1'b0;
  endtask
  task automatic wait_lvl(input logic l);
    for (int i = 0; i < 200 && int_n !== l; i++) tick();
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_reset;
    logic [15:0] a [7] = '{GEN_PEND_OFS, RX_PEND_LO_OFS, RX_PEND_HI_OFS, LABEL_CAP_BASE_OFS,
      RX_IRQ_EN_LO_OFS, RX_IRQ_EN_HI_OFS, 16'h8000};
    foreach (a[i])
    begin
      rd(a[i]);
      `CHK("reset value", 8'h00, v)
    end
    rd(GEN_ENABLE_OFS);
    `CHK("enable reset", 8'hF8, v)
    `CHK("int idle", 1'b1, int_n)
  endtask
  task automatic t_rx;
    lut_set(4'h7, 8'hD4, 1'b1);
    lut_set(4'h3, 8'h55, 1'b0);
    wr(RX_IRQ_EN_LO_OFS, 8'h80);
    rd(RX_IRQ_EN_LO_OFS);
    `CHK("rx enable", 8'h80, v)
    rd(GEN_PEND_OFS);
    send(4'h7, 32'hABCD12D4);
    wait_lvl(1'b0);
    `CHK("int level", 1'b0, int_n)
    wait_lvl(1'b1);
    `CHK("int after ack", 1'b1, int_n)
    rd(LABEL_CAP_BASE_OFS + 16'h0007);
    `CHK("label cap 7", 8'hD4, v)
    send(4'h3, 32'h00000055);
    tick(4);
    rd(RX_PEND_LO_ALT_OFS);
    `CHK("rx pend alt", 8'h80, v)
    rd(RX_PEND_LO_OFS, 2);
    `CHK("rx pend cleared", 8'h00, v)
    rd(GEN_PEND_OFS);
    `CHK("new message bit", 8'h04, v)
  endtask
  task automatic t_fault;
    pulse_mode = 1'b1;
    tick(8);
    for (int i = 0; i < 5; i++)
    begin
      fault = 5'(1 << i);
      tick();
      fault = '0;
      wait_lvl(1'b0);
      `CHK("fault int", 1'b0, int_n)
      wait_lvl(1'b1);
      rd(GEN_PEND_OFS);
      `CHK("fault bit", 8'(1 << (i + 3)), v)
      rd(GEN_PEND_OFS, 2);
      `CHK("fault cleared", 8'h00, v)
    end
  endtask
  task automatic t_fifo;
    wr(GEN_ENABLE_OFS, 8'h03);
    tick();
    wr(TX_FLAG_IRQ_EN_OFS, 8'h04);
    rd(GEN_ENABLE_OFS);
    `CHK("enable rw", 8'hFB, v)
    tx_flag = 8'h04;
    rx_flag = 16'h0020;
    wait_lvl(1'b0);
    `CHK("tx flag int", 1'b0, int_n)
    tick(2);
    rd(GEN_PEND_OFS);
    `CHK("fifo bits", 8'h03, v)
    tx_flag = '0;
    rx_flag = '0;
    wait_lvl(1'b1);
    rd(GEN_PEND_OFS, 2);
    `CHK("fifo cleared", 8'h00, v)
  endtask
  task automatic t_survive;
    lut_set(4'h0, 8'h11, 1'b1);
    req.addr = RX_PEND_LO_OFS;
    req.rd = 1'b1;
    msg = '{valid: 1'b1, channel: 4'h0, word: 32'h00000011};
    tick();
    req.rd = 1'b0;
    msg.valid = 1'b0;
    tick(2);
    rd(RX_PEND_LO_OFS);
    `CHK("set beats clear", 8'h01, v)
    rd(GEN_PEND_OFS, 2);
    wr(GEN_PEND_OFS, 8'h04);
    rd(GEN_PEND_OFS);
    `CHK("bit two write", 8'h04, v)
    lut_set(4'hA, 8'h3C, 1'b1);
    send(4'hA, 32'h1234563C);
    wr(LABEL_CAP_BASE_OFS + 16'h000A, 8'hFF);
    rd(LABEL_CAP_BASE_OFS + 16'h000A);
    `CHK("label cap 10", 8'h3C, v)
    rd(RX_PEND_HI_ALT_OFS);
    `CHK("rx pend high", 8'h04, v)
    rd(GEN_PEND_ALT_OFS);
    `CHK("gen pend alt", 8'h04, v)
    `CHK("masked no int", 1'b1, int_n)
  endtask
  task automatic conclude;
    if (n_mismatch == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      conclude();
    end
  end
  initial
  begin
    tick(4);
    rst_n_i = 1'b1;
    t_reset();
    t_rx();
    t_fault();
    t_fifo();
    t_survive();
    conclude();
  end
endmodule // rtfi_irq_unit_tb
